/* logic/eeprom_access_ctrl.v */
/*
 * Access controller for the on-chip data EEPROM: control register, address
 * and data registers, unlock port, read path, write protection and the
 * completion handshake, plus the program-memory read and row-erase port.
 * Assumes a same-clock program flash that answers PM_RD_O combinationally
 * and pulses PM_DONE_I when a row erase ends; EXT_RESET_I comes from a pin.
 */
`timescale 1ns/10ps
`include "eeprom_regs.vh"

module eeprom_access_ctrl #(
	parameter WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS,
	parameter DEPTH = `DATA_DEPTH
) (
	// Clock, reset and enable
	input wire CLK_I,
	input wire RST_I,
	input wire CE_I,
	// Warm resets
	input wire EXT_RESET_I,
	input wire WDT_RESET_I,
	// Register port
	input wire [`ADDR_W-1:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [7:0] RDATA_O,
	// Program memory port
	output wire [`PM_ADDR_W-1:0] PM_ADDR_O,
	output wire PM_RD_O,
	input wire [`PM_DATA_W-1:0] PM_RDATA_I,
	output reg PM_ERASE_O,
	input wire PM_DONE_I,
	// Status
	output wire STORE_DONE_O,
	output wire BUSY_O
);

	// ------------------------------------------------------------------
	// Unlock sequence states
	// ------------------------------------------------------------------
	localparam [1:0] UL_IDLE = 2'b00;
	localparam [1:0] UL_FIRST = 2'b01;
	localparam [1:0] UL_ARMED = 2'b10;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg ext_meta_ff;
	reg ext_sync_ff;
	reg space_sel_ff;
	reg row_erase_ff;
	reg abort_flag_ff;
	reg permit_ff;
	reg commit_ff;
	reg read_start_ff;
	reg erase_act_ff;
	reg done_flag_ff;
	reg [1:0] unlock_st_ff;
	reg [1:0] nxt_unlock_st;
	reg [7:0] addr_low_ff;
	reg [`ADRH_W-1:0] addr_high_ff;
	reg [7:0] data_low_ff;
	reg [`DATH_W-1:0] data_high_ff;
	reg [7:0] rd_mux;

	wire warm_rst;
	wire wr_ctrl;
	wire wr_unlock;
	wire commit_ok;
	wire start_data;
	wire start_erase;
	wire read_go;
	wire store_busy;
	wire store_done;
	wire erase_done;
	wire op_done;
	wire [7:0] store_q;
	wire [7:0] ctrl_val;

	// ------------------------------------------------------------------
	// External master reset synchroniser
	// ------------------------------------------------------------------
	always @(posedge CLK_I) begin
		if (RST_I) begin
			ext_meta_ff <= 1'b0;
			ext_sync_ff <= 1'b0;
		end else if (CE_I) begin
			ext_meta_ff <= EXT_RESET_I;
			ext_sync_ff <= ext_meta_ff;
		end
	end

	assign warm_rst = ext_sync_ff | WDT_RESET_I;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign wr_ctrl = WR_I && (ADDR_I == `CTRL_OFS);
	assign wr_unlock = WR_I && (ADDR_I == `UNLOCK_OFS);

	// The permit bit is sampled before this write updates it, and the
	// unlock sequence must be armed by the two directly preceding writes.
	assign commit_ok = wr_ctrl && WDATA_I[`B_WR] && permit_ff && !commit_ff && !warm_rst && (unlock_st_ff == UL_ARMED);

	// The target space is the one written in the same cycle as the commit.
	assign start_data = commit_ok && !WDATA_I[`B_PGD];
	assign start_erase = commit_ok && WDATA_I[`B_PGD] && WDATA_I[`B_FREE];

	assign read_go = wr_ctrl && WDATA_I[`B_RD] && !commit_ff && !read_start_ff && !warm_rst;

	// ------------------------------------------------------------------
	// Unlock sequence tracker
	// ------------------------------------------------------------------
	always @* begin
		nxt_unlock_st = unlock_st_ff;
		if (WR_I) begin
			if (wr_unlock && WDATA_I == `KEY_FIRST) begin
				nxt_unlock_st = UL_FIRST;
			end else if (wr_unlock && WDATA_I == `KEY_SECOND && unlock_st_ff == UL_FIRST) begin
				nxt_unlock_st = UL_ARMED;
			end else begin
				// Any other write, including the commit itself, disarms.
				nxt_unlock_st = UL_IDLE;
			end
		end
	end

	always @(posedge CLK_I) begin
		if (RST_I) begin
			unlock_st_ff <= UL_IDLE;
		end else if (CE_I) begin
			if (warm_rst) begin
				unlock_st_ff <= UL_IDLE;
			end else begin
				case (unlock_st_ff)
					UL_IDLE: unlock_st_ff <= nxt_unlock_st;
					UL_FIRST: unlock_st_ff <= nxt_unlock_st;
					UL_ARMED: unlock_st_ff <= nxt_unlock_st;
					default: unlock_st_ff <= UL_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	always @(posedge CLK_I) begin
		if (RST_I) begin
			space_sel_ff <= 1'b0;
			row_erase_ff <= 1'b0;
			abort_flag_ff <= 1'b0;
			permit_ff <= 1'b0;
			commit_ff <= 1'b0;
			read_start_ff <= 1'b0;
		end else if (CE_I) begin
			if (warm_rst) begin
				// A warm reset ends any operation; address and data stay.
				space_sel_ff <= 1'b0;
				permit_ff <= 1'b0;
				commit_ff <= 1'b0;
				read_start_ff <= 1'b0;
				if (commit_ff) begin
					abort_flag_ff <= 1'b1;
				end
			end else begin
				if (wr_ctrl) begin
					if (!commit_ff) begin
						space_sel_ff <= WDATA_I[`B_PGD];
					end
					row_erase_ff <= WDATA_I[`B_FREE];
					abort_flag_ff <= WDATA_I[`B_ERR];
					// Only software and a warm reset move the permit bit; a running write
					// does not look at it again.
					permit_ff <= WDATA_I[`B_WRITE_PERMIT];
				end
				if (start_data || start_erase) begin
					commit_ff <= 1'b1;
				end else if (op_done) begin
					commit_ff <= 1'b0;
				end
				if (read_go) begin
					read_start_ff <= 1'b1;
				end else if (read_start_ff) begin
					read_start_ff <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Address registers
	// ------------------------------------------------------------------
	always @(posedge CLK_I) begin
		if (RST_I) begin
			addr_low_ff <= `BYTE_ZERO;
			addr_high_ff <= {`ADRH_W{1'b0}};
		end else if (CE_I) begin
			if (WR_I && ADDR_I == `ADRL_OFS) begin
				addr_low_ff <= WDATA_I;
			end
			if (WR_I && ADDR_I == `ADRH_OFS) begin
				addr_high_ff <= WDATA_I[`ADRH_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Data registers
	// ------------------------------------------------------------------
	always @(posedge CLK_I) begin
		if (RST_I) begin
			data_low_ff <= `BYTE_ZERO;
			data_high_ff <= {`DATH_W{1'b0}};
		end else if (CE_I) begin
			if (read_start_ff) begin
				if (space_sel_ff) begin
					data_low_ff <= PM_RDATA_I[7:0];
					data_high_ff <= PM_RDATA_I[`PM_DATA_W-1:8];
				end else begin
					data_low_ff <= store_q;
				end
			end else begin
				if (WR_I && ADDR_I == `DATA_OFS) begin
					data_low_ff <= WDATA_I;
				end
				if (WR_I && ADDR_I == `DATH_OFS) begin
					data_high_ff <= WDATA_I[`DATH_W-1:0];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Program memory port
	// ------------------------------------------------------------------
	assign PM_ADDR_O = {addr_high_ff, addr_low_ff};
	assign PM_RD_O = read_start_ff && space_sel_ff;

	always @(posedge CLK_I) begin
		if (RST_I) begin
			PM_ERASE_O <= 1'b0;
			erase_act_ff <= 1'b0;
		end else if (CE_I) begin
			PM_ERASE_O <= start_erase;
			if (start_erase) begin
				erase_act_ff <= 1'b1;
			end else if (PM_DONE_I || warm_rst) begin
				erase_act_ff <= 1'b0;
			end
		end
	end

	assign erase_done = erase_act_ff && PM_DONE_I && !warm_rst;

	// ------------------------------------------------------------------
	// Data array and write timer
	// ------------------------------------------------------------------
	eeprom_store #(
		.WRITE_CYCLES(WRITE_CYCLES),
		.DEPTH(DEPTH)
	) u_store (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.start_i(start_data),
		.abort_i(warm_rst),
		.wr_addr_i(addr_low_ff),
		.wr_data_i(data_low_ff),
		.rd_addr_i(addr_low_ff),
		.rd_data_o(store_q),
		.busy_o(store_busy),
		.done_o(store_done)
	);

	assign op_done = store_done || erase_done;

	// ------------------------------------------------------------------
	// Completion flag
	// ------------------------------------------------------------------
	always @(posedge CLK_I) begin
		if (RST_I) begin
			done_flag_ff <= 1'b0;
		end else if (CE_I) begin
			// A completion in the same cycle as a software clear wins.
			if (op_done) begin
				done_flag_ff <= 1'b1;
			end else if (WR_I && ADDR_I == `FLAG_OFS) begin
				done_flag_ff <= WDATA_I[`B_DONE];
			end
		end
	end

	assign STORE_DONE_O = done_flag_ff;
	assign BUSY_O = commit_ff | store_busy | erase_act_ff;

	// ------------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------------
	assign ctrl_val = {space_sel_ff, 2'b00, row_erase_ff, abort_flag_ff, permit_ff, commit_ff, read_start_ff};

	always @* begin
		rd_mux = `BYTE_ZERO;
		case (ADDR_I)
			`CTRL_OFS: rd_mux = ctrl_val;
			`UNLOCK_OFS: rd_mux = `BYTE_ZERO;
			`DATA_OFS: rd_mux = data_low_ff;
			`DATH_OFS: rd_mux = {{(8-`DATH_W){1'b0}}, data_high_ff};
			`ADRL_OFS: rd_mux = addr_low_ff;
			`ADRH_OFS: rd_mux = {{(8-`ADRH_W){1'b0}}, addr_high_ff};
			`FLAG_OFS: rd_mux = {{(7-`B_DONE){1'b0}}, done_flag_ff, {`B_DONE{1'b0}}};
			default: rd_mux = `BYTE_ZERO;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always @(posedge CLK_I) begin
		if (RST_I) begin
			RDATA_O <= `BYTE_ZERO;
		end else if (CE_I) begin
			if (RD_I) begin
				RDATA_O <= rd_mux;
			end else begin
				RDATA_O <= `BYTE_ZERO;
			end
		end
	end

endmodule // eeprom_access_ctrl

/* pkg/eeprom_regs.vh */
/*
 * Register offsets, bit positions, key values and timing figures for the
 * data EEPROM access controller.
 * Assumes a 9-bit register address space and a 250 MHz clock.
 */
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_W 9
`define CTRL_OFS 9'h18c
`define UNLOCK_OFS 9'h18d
`define DATA_OFS 9'h10c
`define ADRL_OFS 9'h10d
`define DATH_OFS 9'h10e
`define ADRH_OFS 9'h10f
`define FLAG_OFS 9'h00d

// ----------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------
`define B_PGD 7
`define B_FREE 4
`define B_ERR 3
`define B_WRITE_PERMIT 2
`define B_WR 1
`define B_RD 0

// ----------------------------------------------------------------------
// Flag register bits and field widths
// ----------------------------------------------------------------------
`define B_DONE 4
`define ADRH_W 5
`define DATH_W 6
`define PM_ADDR_W 13
`define PM_DATA_W 14

// ----------------------------------------------------------------------
// Unlock keys and reset values
// ----------------------------------------------------------------------
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define BYTE_ZERO 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define WRITE_TIME_NS 4000000
`define DATA_DEPTH 256

`endif

/* logic/eeprom_store.v */
/*
 * Byte-wide data EEPROM array with its write timer.
 * Assumes start_i is a one-cycle pulse given only while busy_o is low.
 */
`timescale 1ns/10ps
`include "eeprom_regs.vh"

module eeprom_store #(
	parameter WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS,
	parameter DEPTH = `DATA_DEPTH
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Write request
	input wire start_i,
	input wire abort_i,
	input wire [7:0] wr_addr_i,
	input wire [7:0] wr_data_i,
	// Read port
	input wire [7:0] rd_addr_i,
	output wire [7:0] rd_data_o,
	// Status
	output wire busy_o,
	output reg done_o
);

	localparam CW = $clog2(WRITE_CYCLES + 1);
	localparam integer LAST_N = WRITE_CYCLES - 1;
	localparam integer DEPTH_N = DEPTH;
	localparam [CW-1:0] LAST = LAST_N[CW-1:0];
	localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
	localparam [8:0] DEPTH_9 = DEPTH_N[8:0];

	reg [7:0] mem [0:DEPTH-1];
	reg busy_ff;
	reg [CW-1:0] cnt_ff;
	reg [7:0] addr_ff;
	reg [7:0] data_ff;

	// Unimplemented locations read as zero.
	assign rd_data_o = ({1'b0, rd_addr_i} < DEPTH_9) ? mem[rd_addr_i] : `BYTE_ZERO;
	assign busy_o = busy_ff;

	// ------------------------------------------------------------------
	// Write timer; the cell is only changed when the timer expires, so an
	// aborted write leaves the old byte in place.
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
			cnt_ff <= CNT_ZERO;
			addr_ff <= `BYTE_ZERO;
			data_ff <= `BYTE_ZERO;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (abort_i) begin
				busy_ff <= 1'b0;
				cnt_ff <= CNT_ZERO;
			end else if (start_i && !busy_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= CNT_ZERO;
				addr_ff <= wr_addr_i;
				data_ff <= wr_data_i;
			end else if (busy_ff) begin
				if (cnt_ff == LAST) begin
					busy_ff <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end

	// Writes to unimplemented locations complete without storing.
	always @(posedge clk_i) begin
		if (ce_i && !abort_i && busy_ff && cnt_ff == LAST && {1'b0, addr_ff} < DEPTH_9) begin
			mem[addr_ff] <= data_ff;
		end
	end

endmodule // eeprom_store

/* sim/eeprom_access_sva.sv */
/* Port assertions for the data EEPROM access controller.
 * Bound to eeprom_access_ctrl; one clock, synchronous active-high reset. */
`timescale 1ns/10ps
`include "eeprom_regs.vh"

module eeprom_access_sva (
	// Clock and reset
	input wire CLK_I,
	input wire RST_I,
	input wire CE_I,
	// Register port
	input wire [`ADDR_W-1:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	input wire [7:0] RDATA_O,
	// Program memory and status
	input wire PM_RD_O,
	input wire PM_ERASE_O,
	input wire STORE_DONE_O,
	input wire BUSY_O
);
	wire ctrl_wr = WR_I && CE_I && ADDR_I == `CTRL_OFS;
	reg commit_ff;
	reg erase_ff;
	reg pread_ff;
	always @(posedge CLK_I) begin
		commit_ff <= ctrl_wr && WDATA_I[`B_WR];
		erase_ff <= ctrl_wr && WDATA_I[`B_PGD] && WDATA_I[`B_FREE] && WDATA_I[`B_WR];
		pread_ff <= ctrl_wr && WDATA_I[`B_PGD] && WDATA_I[`B_RD];
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	property p_unlock_zero; RD_I && CE_I && ADDR_I == `UNLOCK_OFS |=> RDATA_O == 8'h00; endproperty
	a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
	property p_ctrl_gap; RD_I && CE_I && ADDR_I == `CTRL_OFS |=> RDATA_O[6:5] == 2'b00; endproperty
	a_ctrl_gap: assert property (p_ctrl_gap) else $error("control bits 6 5 nonzero");
	property p_rd_idle; CE_I && !RD_I |=> RDATA_O == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_done_hold; STORE_DONE_O && !(WR_I && ADDR_I == `FLAG_OFS) |=> STORE_DONE_O; endproperty
	a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
	property p_done_cause; $rose(STORE_DONE_O) && !$past(WR_I) |-> $fell(BUSY_O); endproperty
	a_done_cause: assert property (p_done_cause) else $error("done flag without completion");
	property p_commit_cause; $rose(BUSY_O) |-> commit_ff; endproperty
	a_commit_cause: assert property (p_commit_cause) else $error("busy without commit write");
	property p_busy_time; $rose(BUSY_O) && !PM_ERASE_O |-> BUSY_O[*5] ##[1:6] !BUSY_O; endproperty
	a_busy_time: assert property (p_busy_time) else $error("write cycle length wrong");
	property p_erase_pulse; PM_ERASE_O |-> erase_ff ##1 !PM_ERASE_O; endproperty
	a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse wrong");
	property p_prog_read; PM_RD_O |-> pread_ff ##1 !PM_RD_O; endproperty
	a_prog_read: assert property (p_prog_read) else $error("program read strobe wrong");
endmodule // eeprom_access_sva

bind eeprom_access_ctrl eeprom_access_sva u_sva (.*);

/* sim/pm_flash_model.sv */
/* Program flash stand-in on the controller's program memory port.
 * Assumes the controller captures the word in the cycle its read strobe is high. */
`timescale 1ns/10ps

module pm_flash_model #(
	parameter ERASE_CYCLES = 5
) (
	// Clock
	input wire clk_i,
	// Requests
	input wire [12:0] addr_i,
	input wire rd_i,
	input wire erase_i,
	// Answers
	output wire [13:0] rdata_o,
	output reg done_o = 1'b0
);
	reg [13:0] junk_ff = 14'h0000;
	integer left_ff = 0;
	// Outside a read the word changes every cycle, so a late capture shows.
	assign rdata_o = rd_i ? {1'b1, addr_i} : junk_ff;
	always @(posedge clk_i) begin
		junk_ff <= junk_ff + 14'h1357;
		done_o <= left_ff == 1;
		if (erase_i) begin
			left_ff <= ERASE_CYCLES;
		end else if (left_ff > 0) begin
			left_ff <= left_ff - 1;
		end
	end
endmodule // pm_flash_model

/* sim/data_eeprom_access_control_bench.sv */
/* Self-checking bench for the data EEPROM access controller.
 * Assumes the flash model on the program port and a short write timer. */
`timescale 1ns/10ps
`include "eeprom_regs.vh"

module data_eeprom_access_control_bench;
	localparam logic [24:0] ROWS [0:11] = '{{`ADRL_OFS, 8'h5a, 8'h5a}, {`ADRH_OFS, 8'hff, 8'h1f},
		{`DATA_OFS, 8'h3c, 8'h3c}, {`DATH_OFS, 8'hff, 8'h3f}, {`CTRL_OFS, 8'h60, 8'h00},
		{`CTRL_OFS, 8'h8c, 8'h8c}, {`CTRL_OFS, 8'h00, 8'h00}, {`UNLOCK_OFS, 8'h55, 8'h00},
		{9'h000, 8'hff, 8'h00}, {`FLAG_OFS, 8'h10, 8'h10}, {`FLAG_OFS, 8'h00, 8'h00}, {9'h1ff, 8'h12, 8'h00}};
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg wdt = 1'b0;
	reg ext_rst = 1'b0;
	reg [8:0] addr = 9'h000;
	reg [7:0] wdata = 8'h00;
	reg wr_s = 1'b0;
	reg rd_s = 1'b0;
	wire [7:0] rdata;
	wire [12:0] pm_addr;
	wire [13:0] pm_word;
	wire pm_rd;
	wire pm_erase;
	wire pm_done;
	wire done;
	wire busy;
	integer n_mismatch = 0;
	integer check_count = 0;
	integer i;
	always #2 clk = ~clk;

	eeprom_access_ctrl #(.WRITE_CYCLES(8), .DEPTH(256)) uut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
		.EXT_RESET_I(ext_rst), .WDT_RESET_I(wdt), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
		.RDATA_O(rdata), .PM_ADDR_O(pm_addr), .PM_RD_O(pm_rd), .PM_RDATA_I(pm_word),
		.PM_ERASE_O(pm_erase), .PM_DONE_I(pm_done), .STORE_DONE_O(done), .BUSY_O(busy));
	pm_flash_model flash (.clk_i(clk), .addr_i(pm_addr), .rd_i(pm_rd), .erase_i(pm_erase),
		.rdata_o(pm_word), .done_o(pm_done));

	task test_done;
		begin
			if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [7:0] seen, input [7:0] exp, input [39:0] nm);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [8:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr_s <= 1'b1;
			@(posedge clk);
			wr_s <= 1'b0;
		end
	endtask
	task rd(input [8:0] a, input [7:0] e, input [39:0] nm);
		begin
			@(posedge clk);
			addr <= a;
			rd_s <= 1'b1;
			@(posedge clk);
			rd_s <= 1'b0;
			#1 chk(rdata, e, nm);
		end
	endtask
	task unlock(input [7:0] c);
		begin
			wr(`UNLOCK_OFS, `KEY_FIRST);
			wr(`UNLOCK_OFS, `KEY_SECOND);
			wr(`CTRL_OFS, c);
			#1;
		end
	endtask
	task wait_idle;
		begin
			for (i = 0; i < 200 && busy !== 1'b0; i = i + 1) @(posedge clk);
			#1 chk({7'h0, busy}, 8'h00, "busy");
			if (busy !== 1'b0) test_done;
		end
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(`CTRL_OFS, 8'h00, "ctrl");
		for (i = 0; i < 12; i = i + 1) begin
			wr(ROWS[i][24:16], ROWS[i][15:8]);
			rd(ROWS[i][24:16], ROWS[i][7:0], "row");
		end
		// Address and data loaded before the key sequence.
		wr(`ADRL_OFS, 8'h21);
		wr(`DATA_OFS, 8'hc3);
		wr(`CTRL_OFS, 8'h04);
		unlock(8'h06);
		chk({7'h0, busy}, 8'h01, "busy");
		wr(`CTRL_OFS, 8'h80);
		wr(`CTRL_OFS, 8'h00);
		rd(`CTRL_OFS, 8'h02, "ctrl");
		wait_idle;
		rd(`CTRL_OFS, 8'h00, "ctrl");
		repeat (30) @(posedge clk);
		rd(`FLAG_OFS, 8'h10, "flag");
		wr(`FLAG_OFS, 8'h00);
		wr(`DATA_OFS, 8'h00);
		wr(`CTRL_OFS, 8'h01);
		rd(`DATA_OFS, 8'hc3, "data");
		rd(`DATA_OFS, 8'hc3, "data");
		// Refused commits: no prior permit, key sequence broken by an address write, reversed keys.
		wr(`DATA_OFS, 8'h11);
		unlock(8'h06);
		chk({7'h0, busy}, 8'h00, "busy");
		wr(`UNLOCK_OFS, `KEY_FIRST);
		wr(`ADRL_OFS, 8'h21);
		wr(`UNLOCK_OFS, `KEY_SECOND);
		wr(`CTRL_OFS, 8'h06);
		#1 chk({7'h0, busy}, 8'h00, "busy");
		wr(`UNLOCK_OFS, `KEY_SECOND);
		wr(`UNLOCK_OFS, `KEY_FIRST);
		wr(`CTRL_OFS, 8'h06);
		#1 chk({7'h0, busy}, 8'h00, "busy");
		wr(`CTRL_OFS, 8'h01);
		rd(`DATA_OFS, 8'hc3, "data");
		wr(`ADRH_OFS, 8'h03);
		wr(`ADRL_OFS, 8'h45);
		wr(`CTRL_OFS, 8'h81);
		rd(`DATA_OFS, 8'h45, "pmlo");
		rd(`DATH_OFS, 8'h23, "pmhi");
		wr(`CTRL_OFS, 8'h94);
		unlock(8'h96);
		chk({7'h0, pm_erase}, 8'h01, "erase");
		wait_idle;
		chk({7'h0, done}, 8'h01, "done");
		wr(`FLAG_OFS, 8'h00);
		// Watchdog cuts a data write short in mid-cycle.
		wr(`ADRL_OFS, 8'h30);
		wr(`DATA_OFS, 8'h77);
		wr(`CTRL_OFS, 8'h04);
		unlock(8'h06);
		repeat (5) @(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		rd(`CTRL_OFS, 8'h08, "ctrl");
		rd(`ADRL_OFS, 8'h30, "adrl");
		rd(`DATA_OFS, 8'h77, "data");
		// External master reset cuts a write short; the stored byte keeps its old value.
		wr(`ADRL_OFS, 8'h21);
		wr(`DATA_OFS, 8'h5a);
		wr(`CTRL_OFS, 8'h04);
		unlock(8'h06);
		repeat (2) @(posedge clk);
		ext_rst <= 1'b1;
		@(posedge clk);
		ext_rst <= 1'b0;
		wait_idle;
		rd(`CTRL_OFS, 8'h08, "ctrl");
		rd(`DATA_OFS, 8'h5a, "data");
		wr(`CTRL_OFS, 8'h01);
		rd(`DATA_OFS, 8'hc3, "data");
		wr(`CTRL_OFS, 8'h84);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`CTRL_OFS, 8'h00, "ctrl");
		test_done;
	end
endmodule // data_eeprom_access_control_bench
